// ===== eel_pkg.sv
package eel_pkg;
    localparam int NUM_LINES = 19;
    localparam int NUM_EXT   = 16;
    localparam int NUM_PINS  = 80;
    localparam int PIN_SEL_W = 7;
    localparam int LINE_SUPPLY = 16;
    localparam int LINE_ALARM  = 17;

    localparam logic [3:0] ADDR_MASK   = 4'h0;
    localparam logic [3:0] ADDR_EVMASK = 4'h1;
    localparam logic [3:0] ADDR_RISE   = 4'h2;
    localparam logic [3:0] ADDR_FALL   = 4'h3;
    localparam logic [3:0] ADDR_SWTRIG = 4'h4;
    localparam logic [3:0] ADDR_PEND   = 4'h5;
    localparam logic [3:0] ADDR_STAT   = 4'h6;
    localparam logic [3:0] ADDR_IEN    = 4'h7;
    localparam logic [3:0] ADDR_SEL0   = 4'h8;

    localparam logic [18:0] LINES_RST = 19'h00000;
    localparam logic [31:0] DATA_ZERO = 32'h00000000;
    localparam logic [1:0]  STAT_PEND_BIT = 2'h1;
    localparam int STAT_W = 2;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } eel_bus_req_t;

    typedef struct packed {
        logic [18:0] rise;
        logic [18:0] fall;
    } eel_trig_t;
endpackage

// ===== eel_edge_capture.sv
module eel_edge_capture (
    input  wire logic sig_in,
    input  wire logic REF_CLK,
    input  wire logic NRST,
    input  wire logic rise_en,
    input  wire logic fall_en,
    input  wire logic ack,
    output logic      hit
);
    logic cap_r_q;
    logic cap_f_q;
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic seen_q;
    logic seen_d;

    // async catch of narrow pulses; cleared from the clock domain
    always_ff @(posedge sig_in or posedge ack) begin
        if (ack) begin
            cap_r_q <= 1'b0;
        end else begin
            cap_r_q <= 1'b1;
        end
    end

    always_ff @(negedge sig_in or posedge ack) begin
        if (ack) begin
            cap_f_q <= 1'b0;
        end else begin
            cap_f_q <= 1'b1;
        end
    end

    always_comb begin
        seen_d = (rise_en & cap_r_q) | (fall_en & cap_f_q);
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            seen_q  <= 1'b0;
        end else begin
            seen_q  <= seen_d;
            sync1_q <= seen_q;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign hit = sync2_q & ~sync3_q;
endmodule

// ===== eel_top.sv
module eel_top (
    input  wire logic                          REF_CLK,
    input  wire logic                          NRST,
    input  wire logic [eel_pkg::NUM_PINS-1:0]  GPIO_IN,
    input  wire logic                          SUPPLY_LOW,
    input  wire logic                          ALARM,
    input  wire logic                          LINE_IN18,
    input  wire logic [3:0]                    ADDR,
    input  wire logic [31:0]                   WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic      [31:0]                   RDATA,
    output logic      [eel_pkg::NUM_LINES-1:0] IRQ_LINES,
    output logic      [eel_pkg::NUM_LINES-1:0] EVENT_PULSE,
    output logic                               WAKE,
    output logic                               IRQ
);
    localparam int N = eel_pkg::NUM_LINES;

    eel_pkg::eel_bus_req_t req;
    eel_pkg::eel_trig_t    trig_q, trig_d;
    logic [N-1:0] mask_q, mask_d, evmask_q, evmask_d, pend_q, pend_d;
    logic [N-1:0] src, hit, ack_q, ack_d, ev_q, ev_d;
    logic [eel_pkg::PIN_SEL_W-1:0] sel_q [eel_pkg::NUM_EXT];
    logic [eel_pkg::PIN_SEL_W-1:0] sel_d [eel_pkg::NUM_EXT];
    logic [eel_pkg::STAT_W-1:0] stat_q, stat_d, ien_q, ien_d;
    logic [31:0] rdata_d, rdata_q;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    function automatic logic is_wr(input eel_pkg::eel_bus_req_t r, input logic [3:0] a);
        return r.wr && r.addr == a;
    endfunction

    function automatic logic [eel_pkg::PIN_SEL_W-1:0] clip_sel(input logic [31:0] w);
        return (w[eel_pkg::PIN_SEL_W-1:0] < eel_pkg::PIN_SEL_W'(eel_pkg::NUM_PINS))
               ? w[eel_pkg::PIN_SEL_W-1:0] : '0;
    endfunction

    genvar g;
    generate
        for (g = 0; g < eel_pkg::NUM_EXT; g++) begin : g_ext
            assign src[g] = GPIO_IN[sel_q[g]];
        end
        for (g = 0; g < N; g++) begin : g_line
            eel_edge_capture u_cap (
                .sig_in  (src[g]),
                .REF_CLK (REF_CLK),
                .NRST    (NRST),
                .rise_en (trig_q.rise[g]),
                .fall_en (trig_q.fall[g]),
                .ack     (ack_q[g]),
                .hit     (hit[g])
            );
        end
    endgenerate
    // below-threshold is a rising detector output; both crossings selectable
    assign src[eel_pkg::LINE_SUPPLY] = SUPPLY_LOW;
    assign src[eel_pkg::LINE_ALARM]  = ALARM;
    assign src[N-1]                  = LINE_IN18;

    always_comb begin
        trig_d   = trig_q;
        mask_d   = mask_q;
        evmask_d = evmask_q;
        ien_d    = ien_q;
        for (int i = 0; i < eel_pkg::NUM_EXT; i++) begin
            sel_d[i] = sel_q[i];
            if (is_wr(req, eel_pkg::ADDR_SEL0 + 4'(i / 4))) begin
                sel_d[i] = clip_sel(32'(req.wdata >> (8 * (i % 4))));
            end
        end
        if (is_wr(req, eel_pkg::ADDR_MASK))   mask_d      = req.wdata[N-1:0];
        if (is_wr(req, eel_pkg::ADDR_EVMASK)) evmask_d    = req.wdata[N-1:0];
        if (is_wr(req, eel_pkg::ADDR_RISE))   trig_d.rise = req.wdata[N-1:0];
        if (is_wr(req, eel_pkg::ADDR_FALL))   trig_d.fall = req.wdata[N-1:0];
        if (is_wr(req, eel_pkg::ADDR_IEN))    ien_d       = req.wdata[eel_pkg::STAT_W-1:0];
    end

    always_comb begin
        logic [N-1:0] swt;
        logic [N-1:0] clr;
        swt = is_wr(req, eel_pkg::ADDR_SWTRIG) ? req.wdata[N-1:0] : '0;
        clr = is_wr(req, eel_pkg::ADDR_PEND) ? req.wdata[N-1:0] : '0;
        // new edge wins over a simultaneous clear
        pend_d = (pend_q & ~clr) | ((hit | swt) & mask_q);
        ev_d   = (hit | swt) & evmask_q;
        ack_d  = hit;
        stat_d = stat_q;
        if (req.rd && req.addr == eel_pkg::ADDR_STAT) stat_d = '0;
        if (|((hit | swt) & mask_q)) stat_d = stat_d | eel_pkg::STAT_PEND_BIT;
    end

    always_comb begin
        rdata_d = eel_pkg::DATA_ZERO;
        if (req.rd) begin
            unique case (req.addr)
                eel_pkg::ADDR_MASK:   rdata_d[N-1:0] = mask_q;
                eel_pkg::ADDR_EVMASK: rdata_d[N-1:0] = evmask_q;
                eel_pkg::ADDR_RISE:   rdata_d[N-1:0] = trig_q.rise;
                eel_pkg::ADDR_FALL:   rdata_d[N-1:0] = trig_q.fall;
                eel_pkg::ADDR_PEND:   rdata_d[N-1:0] = pend_q;
                eel_pkg::ADDR_STAT:   rdata_d[eel_pkg::STAT_W-1:0] = stat_q;
                eel_pkg::ADDR_IEN:    rdata_d[eel_pkg::STAT_W-1:0] = ien_q;
                default: begin
                    for (int i = 0; i < eel_pkg::NUM_EXT; i++) begin
                        if (req.addr == eel_pkg::ADDR_SEL0 + 4'(i / 4)) begin
                            rdata_d[8*(i%4) +: eel_pkg::PIN_SEL_W] = sel_q[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            trig_q   <= '0;
            mask_q   <= eel_pkg::LINES_RST;
            evmask_q <= eel_pkg::LINES_RST;
            pend_q   <= eel_pkg::LINES_RST;
            ack_q    <= '1;    // holds the async captures clear until reset ends
            ev_q     <= eel_pkg::LINES_RST;
            stat_q   <= '0;
            ien_q    <= '0;
            rdata_q  <= eel_pkg::DATA_ZERO;
            for (int i = 0; i < eel_pkg::NUM_EXT; i++) sel_q[i] <= '0;
        end else begin
            trig_q   <= trig_d;
            mask_q   <= mask_d;
            evmask_q <= evmask_d;
            pend_q   <= pend_d;
            ack_q    <= ack_d;
            ev_q     <= ev_d;
            stat_q   <= stat_d;
            ien_q    <= ien_d;
            rdata_q  <= rdata_d;
            for (int i = 0; i < eel_pkg::NUM_EXT; i++) sel_q[i] <= sel_d[i];
        end
    end

    assign RDATA       = rdata_q;
    assign IRQ_LINES   = pend_q;
    assign EVENT_PULSE = ev_q;
    assign WAKE        = |pend_q | |ev_q;
    assign IRQ         = |(stat_q & ien_q);
endmodule

// ===== eel_top_checker.sv
module eel_top_checker (
    input wire logic        REF_CLK,
    input wire logic        NRST,
    input wire logic [3:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic [18:0] IRQ_LINES,
    input wire logic [18:0] EVENT_PULSE,
    input wire logic        WAKE,
    input wire logic        IRQ
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data not idle");
    AST_UNMAPPED: assert property (RD && ADDR > 4'hB |=> RDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_WAKE: assert property (|IRQ_LINES |-> WAKE)
        else $error("pending without wake");
    AST_HOLD: assert property (|($past(IRQ_LINES) & ~IRQ_LINES) |->
        $past(WR && ADDR == eel_pkg::ADDR_PEND)) else $error("pending dropped alone");
    AST_CLEAR: assert property (WR && ADDR == eel_pkg::ADDR_PEND |=>
        (IRQ_LINES & $past(WDATA[18:0])) == 19'h0) else $error("pending not cleared");
    AST_EVENT_ONE: assert property (|EVENT_PULSE |=> (EVENT_PULSE & $past(EVENT_PULSE)) == 19'h0)
        else $error("event pulse too long");
    AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> |(IRQ_LINES & ~$past(IRQ_LINES)) ||
        $past(WR && ADDR == eel_pkg::ADDR_IEN)) else $error("irq without new pending or enable");
    AST_RST_OUT: assert property ($rose(NRST) |-> IRQ_LINES == 19'h0 && !IRQ && !WAKE)
        else $error("outputs not idle after reset");
    AST_STAT_CLR: assert property (RD && ADDR == eel_pkg::ADDR_STAT && $stable(IRQ_LINES) |->
        ##[1:2] !IRQ) else $error("status read left irq");
    C_HIT: cover property ($rose(|IRQ_LINES));
    C_IRQ: cover property ($rose(IRQ));
    C_CLR: cover property ($fell(|IRQ_LINES));
endmodule

bind eel_top eel_top_checker u_chk (.REF_CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .IRQ_LINES, .EVENT_PULSE, .WAKE, .IRQ);

// ===== eel_pin_model.sv
module eel_pin_model (
    output logic [82:0] lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    initial lvl = 83'h0;
    // 10 ns pulse, shorter than one clock period
    task automatic pulse(input int i);
        lvl[i] = ~lvl[i];
        #10;
        lvl[i] = ~lvl[i];
    endtask
    task automatic flip(input int i);
        lvl[i] = ~lvl[i];
    endtask
endmodule

// ===== eel_top_tb.sv
module eel_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;
    logic        nrst;
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [18:0] lines;
    logic        wake;
    logic        irq;
    logic [18:0] evp;
    logic [82:0] lvl;
    int          err_count = 0;
    int          samples_checked = 0;
    int          ev_seen = 0;
    eel_pin_model pins (.lvl(lvl));
    eel_top uut (.REF_CLK(clk), .NRST(nrst), .GPIO_IN(lvl[79:0]), .SUPPLY_LOW(lvl[80]),
        .ALARM(lvl[81]), .LINE_IN18(lvl[82]), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .IRQ_LINES(lines), .EVENT_PULSE(evp), .WAKE(wake), .IRQ(irq));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // counts cycles in which the event pulse of line 2 stands
    always @(posedge clk) begin
        if (evp[2] === 1'b1) ev_seen++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
        @(posedge clk);
    endtask
    task automatic hit(input int i);
        for (int n = 0; n < 10 && lines[i] !== 1'b1; n++) @(posedge clk);
        check({31'h0, lines[i]}, 32'h1);
        check({31'h0, wake}, 32'h1);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        summarize();
    end
    initial begin
        {nrst, wr, rd, addr, wdata} = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_chk(eel_pkg::ADDR_MASK, 32'h0);
        wr_reg(4'hF, 32'hFFFFFFFF);
        rd_chk(4'hF, 32'h0);
        wr_reg(eel_pkg::ADDR_SEL0, 32'h00000500);
        wr_reg(eel_pkg::ADDR_MASK, 32'h0007FFFF);
        rd_chk(eel_pkg::ADDR_MASK, 32'h0007FFFF);
        wr_reg(eel_pkg::ADDR_RISE, 32'h00070002);
        pins.pulse(5);
        hit(1);
        rd_chk(eel_pkg::ADDR_PEND, 32'h2);
        wr_reg(eel_pkg::ADDR_PEND, 32'h2);
        rd_chk(eel_pkg::ADDR_PEND, 32'h0);
        $display("rise test done");
        wr_reg(eel_pkg::ADDR_RISE, 32'h00070000);
        wr_reg(eel_pkg::ADDR_FALL, 32'h00010003);
        wr_reg(eel_pkg::ADDR_MASK, 32'h0007FFFD);
        pins.pulse(5);
        pins.pulse(0);
        hit(0);
        rd_chk(eel_pkg::ADDR_PEND, 32'h1);
        wr_reg(eel_pkg::ADDR_PEND, 32'h1);
        $display("fall and mask test done");
        for (int i = 0; i < 3; i++) begin
            pins.flip(80 + i);
            hit(16 + i);
            rd_chk(eel_pkg::ADDR_PEND, 32'h1 << (16 + i));
            wr_reg(eel_pkg::ADDR_PEND, 32'h0007FFFF);
        end
        pins.flip(80);
        hit(16);
        wr_reg(eel_pkg::ADDR_PEND, 32'h00010000);
        $display("source line test done");
        wr_reg(eel_pkg::ADDR_SEL0, 32'h7F000500);
        rd_chk(eel_pkg::ADDR_SEL0, 32'h00000500);
        wr_reg(eel_pkg::ADDR_EVMASK, 32'h00000004);
        wr_reg(eel_pkg::ADDR_SWTRIG, 32'h00000004);
        rd_chk(eel_pkg::ADDR_PEND, 32'h4);
        check(ev_seen, 32'h1);
        wr_reg(eel_pkg::ADDR_PEND, 32'h4);
        rd_chk(eel_pkg::ADDR_PEND, 32'h0);
        $display("select and event test done");
        check({31'h0, irq}, 32'h0);
        wr_reg(eel_pkg::ADDR_IEN, 32'h1);
        check({31'h0, irq}, 32'h1);
        rd_chk(eel_pkg::ADDR_STAT, 32'h1);
        @(posedge clk);
        #1;
        check({31'h0, irq}, 32'h0);
        $display("status test done");
        summarize();
    end
endmodule
